// ===== pkg/cod_map.svh
`ifndef COD_MAP_SVH
`define COD_MAP_SVH

`define COD_OFS_OPC    8'h00
`define COD_OFS_FLAGS  8'h04
`define COD_OFS_DATA   8'h08
`define COD_OFS_PC     8'h0C
`define COD_OFS_BASE   8'h10
`define COD_OFS_CTRL   8'h14
`define COD_OFS_STAT   8'h18
`define COD_OFS_EA     8'h1C

`define COD_FLAG_C     7
`define COD_FLAG_Z     6
`define COD_FLAG_S     5
`define COD_FLAG_V     4
`define COD_FLAG_D     3
`define COD_FLAG_H     2

`define COD_RST_BYTE   8'h00
`define COD_RST_WORD   16'h0000
`define COD_RST_OPC    32'h0000_0000

`define COD_SEL_NEVER     4'h0
`define COD_SEL_SBELOW    4'h1
`define COD_SEL_SATMOST   4'h2
`define COD_SEL_UATMOST   4'h3
`define COD_SEL_WRAPSET   4'h4
`define COD_SEL_SIGNSET   4'h5
`define COD_SEL_ZSET      4'h6
`define COD_SEL_CSET      4'h7
`define COD_SEL_ALWAYS    4'h8
`define COD_SEL_SATLEAST  4'h9
`define COD_SEL_SABOVE    4'hA
`define COD_SEL_UABOVE    4'hB
`define COD_SEL_WRAPCLR   4'hC
`define COD_SEL_SIGNCLR   4'hD
`define COD_SEL_ZCLR      4'hE
`define COD_SEL_CCLR      4'hF
`endif

// ===== pkg/cod_pkg.sv
package cod_pkg;
  typedef enum logic [3:0] {
    COD_OTHER  = 4'h0, COD_ADD   = 4'h1, COD_ADC  = 4'h2, COD_SUB   = 4'h3,
    COD_BMINUS = 4'h4, COD_OR    = 4'h5, COD_AND  = 4'h6, COD_MCTEST = 4'h7,
    COD_MTEST  = 4'h8, COD_CMP   = 4'h9, COD_XOR  = 4'hA, COD_COPY  = 4'hB,
    COD_LOOP   = 4'hC, COD_SHORT = 4'hD, COD_FAR  = 4'hE, COD_INC   = 4'hF
  } cod_class_e;
  typedef enum logic [1:0] {
    COD_EA_REL = 2'h0, COD_EA_SHORT = 2'h1, COD_EA_LONG = 2'h2, COD_EA_DIRECT = 2'h3
  } cod_ea_e;
endpackage

// ===== logic/cod_decoder.sv
`timescale 1ns/1ns
`include "cod_map.svh"
module cod_decoder
  import cod_pkg::*;
(
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Core state.
  output logic      [7:0]  flags,
  output logic      [15:0] pc,
  output logic             branch_taken
);

  //////////////////////////////////////////////////////////////////////////////

  logic [31:0] opc_word;
  logic [7:0]  dst_val;
  logic [7:0]  src_val;
  logic [15:0] base;
  cod_ea_e     ea_mode;
  logic        go;

  logic        acc;
  logic        wr_done;
  logic [7:0]  opcode;
  logic [7:0]  b2;
  logic [7:0]  b3;
  logic [7:0]  b4;
  logic [3:0]  hn;
  logic [3:0]  ln;
  cod_class_e  op_class;
  logic [3:0]  wreg;
  logic [7:0]  pair_addr;
  logic [2:0]  bit_pos;
  cod_ea_e     eff_mode;
  logic [15:0] ea;
  logic        cond_true;
  logic        is_branch;
  logic        cin;
  logic [8:0]  sum9;
  logic [4:0]  half5;
  logic        ovf;
  logic [7:0]  dec_val;
  logic [31:0] rd_mux;
  logic        rd_hit;

  assign acc     = psel && penable && !pready;
  assign wr_done = psel && penable && pready && pwrite;
  assign opcode  = opc_word[7:0];
  assign b2      = opc_word[15:8];
  assign b3      = opc_word[23:16];
  assign b4      = opc_word[31:24];
  assign hn      = opcode[7:4];
  assign ln      = opcode[3:0];

  //////////////////////////////////////////////////////////////////////////////

  // Evaluates a 4-bit condition selector against the flag byte.
  function automatic logic cond_eval(input logic [3:0] sel, input logic [7:0] f);
    logic c;
    logic z;
    logic s;
    logic v;
    c = f[`COD_FLAG_C];
    z = f[`COD_FLAG_Z];
    s = f[`COD_FLAG_S];
    v = f[`COD_FLAG_V];
    case (sel)
      `COD_SEL_NEVER:    cond_eval = 1'b0;
      `COD_SEL_ALWAYS:   cond_eval = 1'b1;
      `COD_SEL_CSET:     cond_eval = c;
      `COD_SEL_CCLR:     cond_eval = !c;
      `COD_SEL_ZSET:     cond_eval = z;
      `COD_SEL_ZCLR:     cond_eval = !z;
      `COD_SEL_SIGNCLR:  cond_eval = !s;
      `COD_SEL_SIGNSET:  cond_eval = s;
      `COD_SEL_WRAPSET:  cond_eval = v;
      `COD_SEL_WRAPCLR:  cond_eval = !v;
      `COD_SEL_SATLEAST: cond_eval = !(s ^ v);
      `COD_SEL_SBELOW:   cond_eval = s ^ v;
      `COD_SEL_SABOVE:   cond_eval = !(z | (s ^ v));
      `COD_SEL_SATMOST:  cond_eval = z | (s ^ v);
      `COD_SEL_UABOVE:   cond_eval = !c && !z;
      default:        cond_eval = c | z;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////

  // Primary opcode map.
  always_comb begin
    op_class = COD_OTHER;
    if (ln >= 4'h2 && ln <= 4'h6) begin
      case (hn)
        4'h0:    op_class = COD_ADD;
        4'h1:    op_class = COD_ADC;
        4'h2:    op_class = COD_SUB;
        4'h3:    op_class = COD_BMINUS;
        4'h4:    op_class = COD_OR;
        4'h5:    op_class = COD_AND;
        4'h6:    op_class = COD_MCTEST;
        4'h7:    op_class = COD_MTEST;
        4'hA:    op_class = COD_CMP;
        4'hB:    op_class = COD_XOR;
        default: op_class = COD_OTHER;
      endcase
    end else begin
      case (ln)
        4'h8:    op_class = COD_COPY;
        4'h9:    op_class = COD_COPY;
        4'hA:    op_class = COD_LOOP;
        4'hB:    op_class = COD_SHORT;
        4'hC:    op_class = COD_COPY;
        4'hD:    op_class = COD_FAR;
        4'hE:    op_class = COD_INC;
        default: op_class = COD_OTHER;
      endcase
    end
  end

  // Operand fields; short forms carry a working register in a nibble.
  assign wreg      = (ln >= 4'h8) ? hn : b2[7:4];
  assign bit_pos   = b2[3:1];
  assign pair_addr = {b2[7:1], 1'b0};
  assign is_branch = (op_class == COD_SHORT) || (op_class == COD_FAR);
  assign cond_true = cond_eval(hn, flags);

  always_comb begin
    if (op_class == COD_SHORT || op_class == COD_LOOP) begin
      eff_mode = COD_EA_REL;
    end else if (op_class == COD_FAR) begin
      eff_mode = COD_EA_DIRECT;
    end else begin
      eff_mode = ea_mode;
    end
  end

  always_comb begin
    case (eff_mode)
      COD_EA_REL:   ea = pc + {{8{b2[7]}}, b2};
      COD_EA_SHORT: ea = base + {{8{b3[7]}}, b3};
      COD_EA_LONG:  ea = base + {b4, b3};
      default:      ea = {b2, b3};
    endcase
  end

  // Adder; the incoming carry only joins for add-with-carry.
  assign cin     = (op_class == COD_ADC) ? flags[`COD_FLAG_C] : 1'b0;
  assign sum9    = {1'b0, dst_val} + {1'b0, src_val} + {8'h00, cin};
  assign half5   = {1'b0, dst_val[3:0]} + {1'b0, src_val[3:0]} + {4'h0, cin};
  assign ovf     = (dst_val[7] == src_val[7]) && (sum9[7] != dst_val[7]);
  assign dec_val = dst_val - 8'h01;

  //////////////////////////////////////////////////////////////////////////////

  // Software-written registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opc_word <= `COD_RST_OPC;
      base     <= `COD_RST_WORD;
      ea_mode  <= COD_EA_REL;
      go       <= 1'b0;
    end else begin
      go <= wr_done && (paddr == `COD_OFS_CTRL) && pwdata[0];
      if (wr_done && paddr == `COD_OFS_OPC) begin
        opc_word <= pwdata;
      end
      if (wr_done && paddr == `COD_OFS_BASE) begin
        base <= pwdata[15:0];
      end
      if (wr_done && paddr == `COD_OFS_CTRL) begin
        ea_mode <= cod_ea_e'(pwdata[2:1]);
      end
    end
  end

  // Operands; the source is never written by execution.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dst_val <= `COD_RST_BYTE;
      src_val <= `COD_RST_BYTE;
    end else if (wr_done && paddr == `COD_OFS_DATA) begin
      dst_val <= pwdata[7:0];
      src_val <= pwdata[15:8];
    end else if (go && (op_class == COD_ADD || op_class == COD_ADC)) begin
      dst_val <= sum9[7:0];
    end else if (go && op_class == COD_LOOP) begin
      dst_val <= dec_val;
    end
  end

  // Flag byte.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= `COD_RST_BYTE;
    end else if (wr_done && paddr == `COD_OFS_FLAGS) begin
      flags <= pwdata[7:0];
    end else if (go && (op_class == COD_ADD || op_class == COD_ADC)) begin
      flags[`COD_FLAG_C] <= sum9[8];
      flags[`COD_FLAG_Z] <= (sum9[7:0] == 8'h00);
      flags[`COD_FLAG_S] <= sum9[7];
      flags[`COD_FLAG_V] <= ovf;
      flags[`COD_FLAG_D] <= 1'b0;
      flags[`COD_FLAG_H] <= half5[4];
    end
  end

  // Program counter holds the address of the following instruction.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc           <= `COD_RST_WORD;
      branch_taken <= 1'b0;
    end else if (wr_done && paddr == `COD_OFS_PC) begin
      pc <= pwdata[15:0];
    end else if (go && is_branch) begin
      branch_taken <= cond_true;
      if (cond_true) begin
        pc <= ea;
      end
    end else if (go && op_class == COD_LOOP) begin
      branch_taken <= (dec_val != 8'h00);
      if (dec_val != 8'h00) begin
        pc <= ea;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  // Read decode.
  always_comb begin
    rd_hit = 1'b1;
    if (paddr == `COD_OFS_OPC) begin
      rd_mux = opc_word;
    end else if (paddr == `COD_OFS_FLAGS) begin
      rd_mux = {24'h000000, flags};
    end else if (paddr == `COD_OFS_DATA) begin
      rd_mux = {16'h0000, src_val, dst_val};
    end else if (paddr == `COD_OFS_PC) begin
      rd_mux = {16'h0000, pc};
    end else if (paddr == `COD_OFS_BASE) begin
      rd_mux = {16'h0000, base};
    end else if (paddr == `COD_OFS_CTRL) begin
      rd_mux = {29'h00000000, ea_mode, 1'b0};
    end else if (paddr == `COD_OFS_STAT) begin
      rd_mux = {3'h0, branch_taken, cond_true, bit_pos, pair_addr, b2, wreg, op_class};
    end else if (paddr == `COD_OFS_EA) begin
      rd_mux = {16'h0000, ea};
    end else begin
      rd_mux = 32'h00000000;
      rd_hit = 1'b0;
    end
  end

  // One wait state on every transfer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= acc;
      pslverr <= acc && !rd_hit;
      if (acc && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_branch_go;
    go && is_branch;
  endsequence

  sequence s_add_go;
    go && (op_class == COD_ADD || op_class == COD_ADC);
  endsequence

  sequence s_loop_go;
    go && (op_class == COD_LOOP);
  endsequence

  a_never_taken: assert property ((s_branch_go and (hn == `COD_SEL_NEVER))
                                  |=> !branch_taken)
    else $error("selector 0000 took a branch");
  a_always_taken: assert property ((s_branch_go and (hn == `COD_SEL_ALWAYS))
                                   |=> branch_taken)
    else $error("selector 1000 did not branch");
  a_carry_cond: assert property ((s_branch_go and (hn == `COD_SEL_CSET))
                                 |=> branch_taken == $past(flags[7]))
    else $error("carry selector mismatch");
  a_zero_clear: assert property ((s_branch_go and (hn == `COD_SEL_ZCLR))
                                 |=> branch_taken != $past(flags[6]))
    else $error("not-zero selector mismatch");
  a_zero_set: assert property ((s_branch_go and (hn == `COD_SEL_ZSET))
                               |=> branch_taken == $past(flags[6]))
    else $error("zero selector mismatch");
  a_sign_clear: assert property ((s_branch_go and (hn == `COD_SEL_SIGNCLR))
                                 |=> branch_taken == !$past(flags[5]))
    else $error("plus selector mismatch");
  a_wrap_set: assert property ((s_branch_go and (hn == `COD_SEL_WRAPSET))
                               |=> branch_taken == $past(flags[4]))
    else $error("overflow selector mismatch");
  a_signed_below: assert property ((s_branch_go and (hn == `COD_SEL_SBELOW))
                                   |=> branch_taken == ($past(flags[5]) ^ $past(flags[4])))
    else $error("signed below selector mismatch");
  a_signed_above: assert property ((s_branch_go and (hn == `COD_SEL_SABOVE && flags[6]))
                                   |=> !branch_taken)
    else $error("signed above taken with zero set");
  a_unsigned_above: assert property ((s_branch_go and (hn == `COD_SEL_UABOVE && (flags[7] || flags[6])))
                                     |=> !branch_taken)
    else $error("unsigned above taken with carry or zero");
  a_unsigned_atmost: assert property ((s_branch_go and (hn == `COD_SEL_UATMOST))
                                      |=> branch_taken == ($past(flags[7]) | $past(flags[6])))
    else $error("unsigned at most selector mismatch");
  a_falls_through: assert property ((s_branch_go and !cond_true)
                                    |=> $stable(pc) && $stable(flags))
    else $error("false branch changed pc or flags");
  a_loop_count: assert property (s_loop_go
                                 |=> branch_taken == (dst_val != 8'h00) && $stable(flags))
    else $error("loop decrement branch wrong");
  a_add_decode: assert property (ln == 4'h2 && hn == 4'h0 |-> op_class == COD_ADD)
    else $error("add opcode misdecoded");
  a_jump_decode: assert property (ln == 4'hD |-> op_class == COD_FAR && eff_mode == COD_EA_DIRECT)
    else $error("far branch misdecoded");
  a_pair_even: assert property (!pair_addr[0])
    else $error("odd pair address");
  a_add_sum: assert property (s_add_go |=> dst_val == 8'($past(sum9)) && $stable(src_val))
    else $error("add result or source wrong");
  a_add_flags: assert property (s_add_go |=> !flags[3] && flags[7] == $past(sum9[8])
                                && flags[6] == (dst_val == 8'h00))
    else $error("add flags wrong");
  a_adc_carry: assert property ((s_add_go and (op_class == COD_ADC && flags[7]))
                                |=> dst_val == 8'($past(dst_val) + $past(src_val) + 8'h01))
    else $error("add-with-carry ignored the carry");
  a_half_carry: assert property ((s_add_go and (dst_val[3:0] == 4'hF && src_val[3:0] != 4'h0))
                                 |=> flags[`COD_FLAG_H])
    else $error("half-carry not set");
  a_apb_ready: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer not one wait state");

endmodule

// ===== verification/cod_fetch_model.sv
`timescale 1ns/1ns
module cod_fetch_model (
  // Clock.
  input  wire logic        pclk,
  // APB master side.
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [7:0]  paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end

  // One transfer; the released address and data are inverted so stale values never look valid.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask
endmodule

// ===== verification/cod_decoder_tb.sv
`timescale 1ns/1ns
`include "cod_map.svh"
module cod_decoder_tb;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  flags;
  logic [15:0] pc;
  logic        branch_taken;
  int          miscompares;
  int          checks_done;

  // Entries are {adc, carry in, dst, src}.
  localparam logic [17:0] add_tab [7] = '{{2'b00, 16'h1203}, {2'b11, 16'h1003}, {2'b00, 16'h7F01},
    {2'b00, 16'hFF01}, {2'b01, 16'h0F00}, {2'b10, 16'h8080}, {2'b11, 16'hFFFF}};
  localparam logic [15:0] ea_tab [4] = '{16'h1055, 16'h1F80, 16'h3280, 16'h5580};

  cod_decoder u_cod_decoder (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .flags(flags),
    .pc(pc), .branch_taken(branch_taken));
  cod_fetch_model u_cod_fetch_model (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    u_cod_fetch_model.xfer(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r, output logic e);
    u_cod_fetch_model.xfer(1'b0, a, 32'h0000_0000, r, e);
  endtask

  task automatic run_op(input logic [31:0] opc, output logic [31:0] f);
    logic e;
    wr(`COD_OFS_OPC, opc);
    wr(`COD_OFS_CTRL, 32'h0000_0001);
    rd(`COD_OFS_FLAGS, f, e);
  endtask

  // Upper selector bit inverts the test picked by the lower three.
  function automatic logic cond(input logic [3:0] c, input logic [7:0] f);
    logic t;
    case (c[2:0])
      3'h0: t = 1'b0;
      3'h1: t = f[5] ^ f[4];
      3'h2: t = f[6] | (f[5] ^ f[4]);
      3'h3: t = f[7] | f[6];
      3'h4: t = f[4];
      3'h5: t = f[5];
      3'h6: t = f[6];
      default: t = f[7];
    endcase
    return c[3] ? ~t : t;
  endfunction

  function automatic logic [3:0] cls(input logic [7:0] op);
    case (op[3:0])
      4'h2, 4'h3, 4'h4, 4'h5, 4'h6: begin
        if (op[7:4] <= 4'h7) return op[7:4] + 4'h1;
        if (op[7:4] == 4'hA) return 4'h9;
        if (op[7:4] == 4'hB) return 4'hA;
        return 4'h0;
      end
      4'h8, 4'h9, 4'hC: return 4'hB;
      4'hA: return 4'hC;
      4'hB: return 4'hD;
      4'hD: return 4'hE;
      4'hE: return 4'hF;
      default: return 4'h0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [31:0] r;
    logic        e;
    chk({24'h0, flags}, 32'h0000_0000);
    chk({16'h0, pc}, 32'h0000_0000);
    chk({31'h0, branch_taken}, 32'h0000_0000);
    rd(`COD_OFS_STAT, r, e);
    chk(r, 32'h0000_0000);
  endtask

  task automatic t_branch;
    logic [31:0] r;
    logic [15:0] tgt;
    logic [7:0]  f0;
    logic [7:0]  b2;
    logic        tk;
    logic        e;
    for (int f = 0; f < 16; f++) begin
      for (int c = 0; c < 16; c++) begin
        f0 = {f[3:0], 4'hA};
        b2 = f[1] ? 8'h7F : 8'h80;
        tk = cond(c[3:0], f0);
        tgt = f[0] ? {b2, 8'h34} : 16'h1000 + {{8{b2[7]}}, b2};
        wr(`COD_OFS_FLAGS, {24'h0, f0});
        wr(`COD_OFS_PC, 32'h0000_1000);
        run_op({8'h00, 8'h34, b2, c[3:0], f[0] ? 4'hD : 4'hB}, r);
        chk(r, {24'h0, f0});
        chk({31'h0, branch_taken}, {31'h0, tk});
        chk({16'h0, pc}, {16'h0, tk ? tgt : 16'h1000});
        rd(`COD_OFS_STAT, r, e);
        chk(32'({r[28:27], r[3:0]}), 32'({tk, tk, f[0] ? 4'hE : 4'hD}));
      end
    end
  endtask

  task automatic t_add;
    logic [31:0] r;
    logic [8:0]  sum;
    logic [7:0]  d;
    logic [7:0]  s;
    logic [7:0]  ef;
    logic        adc;
    logic        ci;
    logic        h;
    logic        e;
    for (int i = 0; i < 7; i++) begin
      {adc, ci, d, s} = add_tab[i];
      sum = {1'b0, d} + {1'b0, s} + {8'h00, adc & ci};
      h = ({1'b0, d[3:0]} + {1'b0, s[3:0]} + {4'h0, adc & ci}) > 5'h0F;
      ef = {sum[8], sum[7:0] == 8'h00, sum[7], d[7] == s[7] && sum[7] != d[7], 1'b0, h, 2'b01};
      wr(`COD_OFS_FLAGS, {24'h0, ci, 7'b010_1101});
      wr(`COD_OFS_DATA, {16'h0, s, d});
      run_op({24'h0, adc ? 4'h1 : 4'h0, 4'h2 + 4'(i % 5)}, r);
      chk(r, {24'h0, ef});
      rd(`COD_OFS_DATA, r, e);
      chk({16'h0, r[15:0]}, {16'h0, s, sum[7:0]});
    end
  endtask

  task automatic t_loop;
    logic [31:0] r;
    logic        e;
    wr(`COD_OFS_FLAGS, 32'h0000_00A5);
    wr(`COD_OFS_DATA, 32'h0000_3302);
    wr(`COD_OFS_PC, 32'h0000_1000);
    for (int k = 0; k < 2; k++) begin
      run_op(32'h0000_105A, r);
      chk(r, 32'h0000_00A5);
      chk({31'h0, branch_taken}, 32'(k == 0));
      chk({16'h0, pc}, 32'h0000_1010);
      rd(`COD_OFS_DATA, r, e);
      chk(r, 32'h0000_3301 - 32'(k));
    end
  endtask

  task automatic t_decode;
    logic [31:0] r;
    logic [3:0]  w;
    logic        e;
    for (int o = 0; o < 256; o++) begin
      wr(`COD_OFS_OPC, {16'h0, 8'hB7, o[7:0]});
      rd(`COD_OFS_STAT, r, e);
      w = (o[3:0] >= 4'h8) ? o[7:4] : 4'hB;
      chk(32'(r[26:0]), 32'({3'b011, 8'hB6, 8'hB7, w, cls(o[7:0])}));
    end
  endtask

  task automatic t_ea;
    logic [31:0] r;
    logic        e;
    wr(`COD_OFS_PC, 32'h0000_1000);
    wr(`COD_OFS_BASE, 32'h0000_2000);
    wr(`COD_OFS_OPC, 32'h1280_55E4);
    for (int m = 0; m < 4; m++) begin
      wr(`COD_OFS_CTRL, {29'h0, m[1:0], 1'b0});
      rd(`COD_OFS_EA, r, e);
      chk(r, {16'h0, ea_tab[m]});
    end
  endtask

  task automatic t_bus;
    logic [31:0] r;
    logic [31:0] s0;
    logic        e;
    rd(8'h20, r, e);
    chk({31'h0, e}, 32'h0000_0001);
    chk(r, 32'h0000_0000);
    rd(`COD_OFS_STAT, s0, e);
    wr(`COD_OFS_STAT, 32'hFFFF_FFFF);
    rd(`COD_OFS_STAT, r, e);
    chk(r, s0);
    chk({31'h0, e}, 32'h0000_0000);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    miscompares = 0;
    checks_done = 0;
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_branch;
    t_add;
    t_loop;
    t_decode;
    t_ea;
    t_bus;
    final_report;
  end

  initial begin
    #200000;
    miscompares++;
    final_report;
  end
endmodule
